// ==== logic/blit_regs.vh ====
// Register offsets, command fields, opcodes and reset values of the copy and readout engine.
`ifndef BLIT_REGS_VH
`define BLIT_REGS_VH
// Register byte offsets on the register bus.
`define OFS_COMMAND 8'h00
`define OFS_STATUS 8'h04
`define OFS_WINDOW 8'h10
`define OFS_SOURCE 8'h14
`define OFS_CORNER 8'h18
`define OFS_INK 8'h1C
`define OFS_EXTENT 8'h20
`define OFS_PAPER 8'h24
`define OFS_DEPTH 8'h28
`define OFS_DATAPORT 8'h2C
`define OFS_CUR_ADDR 8'h30
`define OFS_REMAIN 8'h34
`define OFS_ROW_PIX 8'h38
`define OFS_LEFT 8'h3C
`define OFS_LAST_ADDR 8'h40
`define OFS_RESUME 8'h44
// Command word fields.
`define CMD_CODE_HI 3
`define CMD_CODE_LO 0
`define CMD_DEPTH 27
`define CMD_PLANE_HI 26
`define CMD_PLANE_LO 24
`define CMD_SOLID 23
`define CMD_TRANSP 22
`define CMD_EXPAND 21
`define CMD_TILE 20
`define CMD_WTAG 19
`define CMD_LOGIC_HI 11
`define CMD_LOGIC_LO 8
// Command codes.
`define CODE_COPY 4'h1
`define CODE_READOUT 4'h6
// Status bits.
`define ST_HOLD 0
`define ST_ACTIVE 1
// Tile edge is 32 pixels, so five low coordinate bits wrap.
`define TILE_BITS 5
// Reset value of every software register.
`define REG_RESET 32'h00000000
// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ==== logic/block_copy_and_readout_engine.v ====
// Block copy and rectangle readout engine with an AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
`include "blit_regs.vh"
// What this block does
// - Command code 1 plus a corner write starts a block copy.
// - Command word holds depth, plane, solid, transparent, expand, tile, tag, logic fields.
// - Normal copy writes the chosen Boolean of source and destination pixels.
// - Solid fill writes the ink low byte, reads no source, ignores expand, transparency, tile and logic.
// - Plane expand picks a source plane bit: one gives ink, zero gives paper.
// - Expand with transparency leaves the destination alone where the bit is zero.
// - Tile mode repeats a 32 by 32 source tile over the destination.
// - Host writes command, then parameters, corner last; the corner write starts it.
// - Finishing a block copy pulses the drawing done interrupt.
// - No rectangle clipping on copy, but window tag clipping when enabled.
// - Depth bit leaves copy alone; with solid it also clears the depth buffer.
// - Command code 6 starts a readout using window, corner, extent and data port.
// - Readout fetches words itself and holds the next until the host reads.
// - Readout words go left to right, rows top to bottom.
// - Each readout word carries one bit per plane, plane 0 in bit 0.
// - Finishing a readout pulses the drawing done interrupt.
module block_copy_and_readout_engine (
   // Clock and reset.
   input wire clk_i,
   input wire reset_i,
   // AXI4-Lite write address and data.
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   // AXI4-Lite write response.
   output wire [1:0] s_axi_bresp_o,
   output wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // AXI4-Lite read address and data.
   input wire [7:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0] s_axi_rresp_o,
   output wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // Frame buffer pixel port.
   output wire fb_rd_o,
   output wire fb_wr_o,
   output wire [15:0] fb_x_o,
   output wire [15:0] fb_y_o,
   output wire [7:0] fb_wdata_o,
   input wire [7:0] fb_rdata_i,
   input wire fb_ack_i,
   // Window tag test of the pixel at fb_x_o, fb_y_o.
   input wire wid_ok_i,
   // Depth buffer fast clear.
   output wire fb_zclr_o,
   output wire [31:0] fb_zdata_o,
   // Drawing done.
   output wire draw_done_irq_o
);

   localparam [2:0] ST_IDLE = 3'h0, ST_PIX = 3'h1, ST_SRC = 3'h2, ST_DST = 3'h3;
   localparam [2:0] ST_WR = 3'h4, ST_NEXT = 3'h5, ST_RFETCH = 3'h6, ST_RHOLD = 3'h7;

   // Software registers.
   reg [31:0] command_word_q, window_corner_param_q, source_param_q, transfer_corner_param_q;
   reg [31:0] ink_param_q, transfer_extent_param_q, paper_q, depth_value_q;
   // Engine state.
   reg [2:0] state_q;
   reg readout_q;
   reg [15:0] col_q, row_q;
   reg [7:0] src_pix_q;
   reg [7:0] wdata_q;
   reg skip_q;
   reg [7:0] word_q;
   reg [31:0] last_fetch_address_q;
   reg [31:0] resume_extent_q;
   reg done_q;
   // Bus slave state.
   reg [7:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.
   // Bitwise logic unit: the code bit picked by inverted source and destination.
   function [7:0] logic_fn;
      input [3:0] code;
      input [7:0] s;
      input [7:0] d;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            logic_fn[i] = code[{~s[i], ~d[i]}];
         end
      end
   endfunction

   // Byte lane merge of a register write.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Field decode and coordinates.
   wire [3:0] cmd_code = command_word_q[`CMD_CODE_HI:`CMD_CODE_LO];
   wire depth_test_on = command_word_q[`CMD_DEPTH];
   wire [2:0] plane_sel = command_word_q[`CMD_PLANE_HI:`CMD_PLANE_LO];
   wire solid = command_word_q[`CMD_SOLID];
   wire transp = command_word_q[`CMD_TRANSP];
   wire expand = command_word_q[`CMD_EXPAND];
   wire tile = command_word_q[`CMD_TILE];
   wire window_tag_clip = command_word_q[`CMD_WTAG];
   wire [3:0] logic_function = command_word_q[`CMD_LOGIC_HI:`CMD_LOGIC_LO];
   wire [15:0] size_x = transfer_extent_param_q[31:16];
   wire [15:0] size_y = transfer_extent_param_q[15:0];
   // Absolute left and top of the rectangle, relative to the window.
   wire [15:0] left_x = window_corner_param_q[31:16] + transfer_corner_param_q[31:16];
   wire [15:0] top_y = window_corner_param_q[15:0] + transfer_corner_param_q[15:0];
   wire [15:0] dst_x = left_x + col_q;
   wire [15:0] dst_y = top_y + row_q;
   wire [15:0] lin_sx = source_param_q[31:16] + col_q;
   wire [15:0] lin_sy = source_param_q[15:0] + row_q;
   // Tile mode wraps the low five bits inside the 32 by 32 tile.
   wire [15:0] src_x = tile ? {source_param_q[31:21], lin_sx[`TILE_BITS-1:0]} : lin_sx;
   wire [15:0] src_y = tile ? {source_param_q[15:5], lin_sy[`TILE_BITS-1:0]} : lin_sy;
   wire last_col = (col_q + 16'h0001) >= size_x;
   wire last_pix = last_col && ((row_q + 16'h0001) >= size_y);
   wire busy = (state_q != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Pixel colour path.
   // Expanded colour: selected source plane bit picks ink or paper.
   wire plane_bit = src_pix_q[plane_sel];
   wire [7:0] fg = expand ? (plane_bit ? ink_param_q[7:0] : paper_q[7:0]) : src_pix_q;
   wire [7:0] blend = logic_fn(logic_function, fg, fb_rdata_i);
   // Transparent expansion skips zero bits; solid fill never skips.
   wire transp_skip = expand && transp && !plane_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus: write side.
   wire wr_go = aw_have_q && w_have_q && !bvalid_q;
   wire wr_corner = wr_go && (aw_addr_q == `OFS_CORNER);
   wire start = wr_corner && !busy;
   assign s_axi_awready_o = !aw_have_q && !bvalid_q;
   assign s_axi_wready_o = !w_have_q && !bvalid_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   // Address and data are caught in either order; the response follows both.
   always @(posedge clk_i) begin
      if (reset_i) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_have_q <= 1'b0;
         w_data_q <= `REG_RESET;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (aw_addr_q > `OFS_RESUME || aw_addr_q[1:0] != 2'h0) ?
               `RESP_DECERR : `RESP_OKAY;
         end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   // Software registers; command and corner writes are dropped while busy.
   always @(posedge clk_i) begin
      if (reset_i) begin
         command_word_q <= `REG_RESET;
         window_corner_param_q <= `REG_RESET;
         source_param_q <= `REG_RESET;
         transfer_corner_param_q <= `REG_RESET;
         ink_param_q <= `REG_RESET;
         transfer_extent_param_q <= `REG_RESET;
         paper_q <= `REG_RESET;
         depth_value_q <= `REG_RESET;
      end else if (wr_go) begin
         case (aw_addr_q)
            `OFS_COMMAND: begin
               if (!busy) begin
                  command_word_q <= merge(command_word_q, w_data_q, w_strb_q);
               end
            end
            `OFS_WINDOW: begin
               window_corner_param_q <= merge(window_corner_param_q, w_data_q, w_strb_q);
            end
            `OFS_SOURCE: source_param_q <= merge(source_param_q, w_data_q, w_strb_q);
            `OFS_CORNER: begin
               if (!busy) begin
                  transfer_corner_param_q <= merge(transfer_corner_param_q, w_data_q, w_strb_q);
               end
            end
            `OFS_INK: ink_param_q <= merge(ink_param_q, w_data_q, w_strb_q);
            `OFS_EXTENT: begin
               transfer_extent_param_q <= merge(transfer_extent_param_q, w_data_q, w_strb_q);
            end
            `OFS_PAPER: paper_q <= merge(paper_q, w_data_q, w_strb_q);
            `OFS_DEPTH: depth_value_q <= merge(depth_value_q, w_data_q, w_strb_q);
            default: command_word_q <= command_word_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register bus: read side.
   wire ar_dp = (s_axi_araddr_i == `OFS_DATAPORT);
   // A data port read during readout waits until a word is prefetched.
   wire dp_wait = ar_dp && readout_q && busy && (state_q != ST_RHOLD);
   assign s_axi_arready_o = !rvalid_q && !dp_wait;
   wire ar_go = s_axi_arvalid_i && s_axi_arready_o;
   wire dp_take = ar_go && ar_dp && (state_q == ST_RHOLD);
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   // Read data mux, captured when the address is taken.
   always @(posedge clk_i) begin
      if (reset_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= `REG_RESET;
         rresp_q <= `RESP_OKAY;
      end else if (ar_go) begin
         rvalid_q <= 1'b1;
         rresp_q <= `RESP_OKAY;
         case (s_axi_araddr_i)
            `OFS_COMMAND: rdata_q <= command_word_q;
            `OFS_STATUS: rdata_q <= {30'h00000000, busy, busy};
            `OFS_WINDOW: rdata_q <= window_corner_param_q;
            `OFS_SOURCE: rdata_q <= source_param_q;
            `OFS_CORNER: rdata_q <= transfer_corner_param_q;
            `OFS_INK: rdata_q <= ink_param_q;
            `OFS_EXTENT: rdata_q <= transfer_extent_param_q;
            `OFS_PAPER: rdata_q <= paper_q;
            `OFS_DEPTH: rdata_q <= depth_value_q;
            `OFS_DATAPORT: rdata_q <= {24'h000000, word_q};
            `OFS_CUR_ADDR: rdata_q <= {dst_x, dst_y};
            `OFS_REMAIN: rdata_q <= {size_x - col_q, size_y - row_q};
            `OFS_ROW_PIX: rdata_q <= {size_x, 16'h0000};
            `OFS_LEFT: rdata_q <= {left_x, 16'h0000};
            `OFS_LAST_ADDR: rdata_q <= last_fetch_address_q;
            `OFS_RESUME: rdata_q <= resume_extent_q;
            default: begin
               rdata_q <= `REG_RESET;
               rresp_q <= `RESP_DECERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drawing engine.
   // Walks the rectangle a pixel at a time, left to right, top to bottom.
   always @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         readout_q <= 1'b0;
         col_q <= 16'h0000;
         row_q <= 16'h0000;
         src_pix_q <= 8'h00;
         wdata_q <= 8'h00;
         skip_q <= 1'b0;
         word_q <= 8'h00;
         last_fetch_address_q <= `REG_RESET;
         resume_extent_q <= `REG_RESET;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               col_q <= 16'h0000;
               row_q <= 16'h0000;
               if (start && cmd_code == `CODE_COPY) begin
                  readout_q <= 1'b0;
                  state_q <= ST_PIX;
               end else if (start && cmd_code == `CODE_READOUT) begin
                  readout_q <= 1'b1;
                  state_q <= ST_RFETCH;
               end
            end
            ST_PIX: begin
               if (size_x == 16'h0000 || size_y == 16'h0000) begin
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end else if (solid) begin
                  wdata_q <= ink_param_q[7:0];
                  skip_q <= 1'b0;
                  state_q <= ST_WR;
               end else begin
                  state_q <= ST_SRC;
               end
            end
            ST_SRC: begin
               if (fb_ack_i) begin
                  src_pix_q <= fb_rdata_i;
                  state_q <= ST_DST;
               end
            end
            ST_DST: begin
               if (fb_ack_i) begin
                  wdata_q <= blend;
                  skip_q <= transp_skip;
                  state_q <= ST_WR;
               end
            end
            ST_WR: begin
               if (fb_ack_i || !fb_wr_o) begin
                  state_q <= ST_NEXT;
               end
            end
            ST_RFETCH: begin
               if (size_x == 16'h0000 || size_y == 16'h0000) begin
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end else if (fb_ack_i) begin
                  word_q <= fb_rdata_i;
                  last_fetch_address_q <= {dst_x, dst_y};
                  resume_extent_q <= {size_x - col_q, size_y - row_q};
                  state_q <= ST_RHOLD;
               end
            end
            ST_RHOLD: begin
               if (dp_take) begin
                  state_q <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (last_pix) begin
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end else begin
                  col_q <= last_col ? 16'h0000 : col_q + 16'h0001;
                  row_q <= last_col ? row_q + 16'h0001 : row_q;
                  state_q <= readout_q ? ST_RFETCH : ST_PIX;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame buffer port.
   // Source reads in the source state; all else addresses the destination.
   wire src_phase = (state_q == ST_SRC);
   wire rfetch_go = (state_q == ST_RFETCH) && size_x != 16'h0000 && size_y != 16'h0000;
   assign fb_rd_o = src_phase || (state_q == ST_DST) || rfetch_go;
   assign fb_x_o = src_phase ? src_x : dst_x;
   assign fb_y_o = src_phase ? src_y : dst_y;
   // Window tag clipping only; no rectangle clipping is applied here.
   assign fb_wr_o = (state_q == ST_WR) && !skip_q && !(window_tag_clip && !wid_ok_i);
   assign fb_wdata_o = wdata_q;
   // Depth fast clear rides along with solid fill writes when the depth bit is set.
   assign fb_zclr_o = fb_wr_o && solid && depth_test_on;
   assign fb_zdata_o = depth_value_q;
   assign draw_done_irq_o = done_q;

endmodule
`default_nettype wire

// ==== test/engine_props.sv ====
// Checker of the engine's bus and pixel port timing.
`timescale 1ns/100ps
`default_nettype none
module engine_props (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // Register bus.
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   // Pixel port and events.
   input wire logic fb_rd_o,
   input wire logic fb_wr_o,
   input wire logic [15:0] fb_x_o,
   input wire logic [15:0] fb_y_o,
   input wire logic fb_ack_i,
   input wire logic fb_zclr_o,
   input wire logic draw_done_irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // Both write halves taken at one edge.
   sequence s_wr_taken;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   // No pulse and no pixel request for two cycles.
   sequence s_quiet;
      (!draw_done_irq_o && !fb_rd_o && !fb_wr_o) [*2];
   endsequence
   property p_wr_resp;
      s_wr_taken |=> ##1 s_axi_bvalid_o;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
   property p_b_hold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_block;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("second read accepted");
   property p_req_hold;
      fb_rd_o && !fb_ack_i |=> fb_rd_o && $stable(fb_x_o) && $stable(fb_y_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("pixel read not held");
   property p_excl;
      !(fb_rd_o && fb_wr_o);
   endproperty
   a_excl: assert property (p_excl) else $error("read and write together");
   property p_zclr;
      fb_zclr_o |-> fb_wr_o;
   endproperty
   a_zclr: assert property (p_zclr) else $error("depth clear without write");
   property p_done;
      draw_done_irq_o |=> s_quiet;
   endproperty
   a_done: assert property (p_done) else $error("work after done pulse");
endmodule
`default_nettype wire

// ==== test/fb_model.sv ====
// Frame buffer model answering pixel reads and writes.
`timescale 1ns/100ps
`default_nettype none
module fb_model (
   // Clock and pacing.
   input wire logic clk_i,
   input wire logic slow_i,
   // Pixel port.
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [15:0] x_i,
   input wire logic [15:0] y_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic ack_o
);
   logic [7:0] mem [8192];
   logic [1:0] wait_q;
   wire [12:0] idx = {y_i[5:0], x_i[6:0]};
   // Neighbouring pixels differ so misplaced accesses show.
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ i[12:5];
      wait_q = 2'h0;
      ack_o = 1'b0;
      rdata_o = 8'h00;
   end
   // Answer a held request; data outside the ack cycle toggles.
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if ((rd_i || wr_i) && !ack_o) begin
         if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
            ack_o <= 1'b1;
            wait_q <= 2'h0;
            rdata_o <= mem[idx];
            if (wr_i) mem[idx] <= wdata_i;
         end else wait_q <= wait_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the copy and readout engine.
`timescale 1ns/100ps
`default_nettype none
`include "blit_regs.vh"
module tb_top;
   logic clk_i = 0, reset_i = 1, aw_valid = 0, w_valid = 0, b_ready = 0;
   logic ar_valid = 0, r_ready = 0, wid_ok = 1, slow = 0;
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
   logic [31:0] w_data = 32'h00000000;
   wire aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, fb_rd, fb_wr, fb_ack, zclr, irq;
   wire [1:0] b_resp, r_resp;
   wire [31:0] r_data, zdat;
   wire [15:0] fb_x, fb_y;
   wire [7:0] fb_wd, fb_rdat;
   int mismatches = 0, comparisons = 0, cycles = 0, irqs = 0, rds = 0, zclrs = 0;
   block_copy_and_readout_engine DUT (.clk_i(clk_i), .reset_i(reset_i),
      .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_rdy),
      .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_valid),
      .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
      .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
      .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
      .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready), .fb_rd_o(fb_rd), .fb_wr_o(fb_wr),
      .fb_x_o(fb_x), .fb_y_o(fb_y), .fb_wdata_o(fb_wd), .fb_rdata_i(fb_rdat),
      .fb_ack_i(fb_ack), .wid_ok_i(wid_ok), .fb_zclr_o(zclr), .fb_zdata_o(zdat),
      .draw_done_irq_o(irq));
   fb_model FB (.clk_i(clk_i), .slow_i(slow), .rd_i(fb_rd), .wr_i(fb_wr), .x_i(fb_x),
      .y_i(fb_y), .wdata_i(fb_wd), .rdata_o(fb_rdat), .ack_o(fb_ack));
   // Clock and event counters; the cycle ceiling cuts a hang short.
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (fb_rd === 1'b1 && fb_ack === 1'b1) rds <= rds + 1;
      if (zclr === 1'b1 && fb_ack === 1'b1) zclrs <= zclrs + 1;
      if (cycles == 40000) begin
         mismatches++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("Comparisons %0d, mismatches %0d.", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // One register access: write when wr is set; channels are released as they are taken.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] rsp);
      logic ta, tw, tr, pend;
      @(posedge clk_i);
      if (wr) begin
         aw_addr <= a;
         w_data <= d;
         aw_valid <= 1'b1;
         w_valid <= 1'b1;
         b_ready <= 1'b1;
      end else begin
         ar_addr <= a;
         ar_valid <= 1'b1;
         r_ready <= 1'b1;
      end
      pend = 1'b1;
      while (pend) begin
         @(negedge clk_i);
         ta = aw_valid & aw_rdy;
         tw = w_valid & w_rdy;
         tr = ar_valid & ar_rdy;
         q = r_data;
         rsp = wr ? b_resp : r_resp;
         pend = wr ? (b_valid !== 1'b1) : (r_valid !== 1'b1);
         @(posedge clk_i);
         if (ta) aw_valid <= 1'b0;
         if (tw) w_valid <= 1'b0;
         if (tr) ar_valid <= 1'b0;
      end
      b_ready <= 1'b0;
      r_ready <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b1, a, d, q, r);
   endtask
   task automatic idle;
      logic [31:0] s;
      logic [1:0] r;
      s = 32'h00000003;
      while (s[1:0] !== 2'b00) bus(1'b0, `OFS_STATUS, 32'h0, s, r);
   endtask
   function automatic logic [7:0] px(int x, int y);
      return FB.mem[{y[5:0], x[6:0]}];
   endfunction
   function automatic logic [31:0] pk(int x, int y);
      return {x[15:0], y[15:0]};
   endfunction
   // Command first, corner last; one done pulse per command.
   task automatic run(input logic [31:0] cmd, src, dst, ext);
      int n;
      idle();
      n = irqs;
      wr(`OFS_COMMAND, cmd);
      wr(`OFS_SOURCE, src);
      wr(`OFS_EXTENT, ext);
      wr(`OFS_CORNER, dst);
      idle();
      chk("done pulse", irqs - n, 1);
   endtask
   // Reset values, read back, unmapped place.
   task automatic t_regs;
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b0, `OFS_COMMAND, 32'h0, q, r);
      chk("command reset", q, `REG_RESET);
      bus(1'b0, `OFS_STATUS, 32'h0, q, r);
      chk("status reset", q, `REG_RESET);
      wr(`OFS_WINDOW, pk(5, 6));
      bus(1'b0, `OFS_WINDOW, 32'h0, q, r);
      chk("window", q, pk(5, 6));
      wr(`OFS_WINDOW, 32'h0);
      bus(1'b1, 8'h80, 32'h1, q, r);
      chk("unmapped write", r, `RESP_DECERR);
      bus(1'b0, 8'h80, 32'h0, q, r);
      chk("unmapped read", {r, q[29:0]}, {`RESP_DECERR, 30'h0});
   endtask
   // Four logic codes (clear, copy, xor, set) against the source, prompt and slow memory.
   task automatic t_logic;
      logic [3:0] codes [4] = '{4'h0, 4'h3, 4'h6, 4'hF};
      logic [7:0] s, d, e;
      for (int k = 0; k < 4; k++) begin
         slow <= k[0];
         s = px(48, 0);
         d = px(2, 10 + k);
         for (int b = 0; b < 8; b++) e[b] = codes[k][{~s[b], ~d[b]}];
         run({20'h0, codes[k], 8'h01}, pk(48, 0), pk(2, 10 + k), pk(1, 1));
         chk("logic result", px(2, 10 + k), e);
      end
   endtask
   // Solid fill with depth bit: ink low byte, no source reads.
   task automatic t_solid;
      int n;
      idle();
      wr(`OFS_INK, 32'h0000A55A);
      wr(`OFS_DEPTH, 32'h0000BEEF);
      n = rds;
      run(32'h08C00601, pk(48, 1), pk(4, 20), pk(3, 2));
      chk("solid reads", rds - n, 0);
      chk("depth clears", zclrs, 6);
      chk("depth value", zdat, 32'h0000BEEF);
      for (int i = 0; i < 6; i++) chk("solid pixel", px(4 + i % 3, 20 + i / 3), 8'h5A);
   endtask
   // Plane expansion, then with transparency.
   task automatic t_expand;
      logic [7:0] s [4], d [4];
      idle();
      wr(`OFS_INK, 32'h000000C3);
      wr(`OFS_PAPER, 32'h0000003C);
      for (int t = 0; t < 2; t++) begin
         for (int i = 0; i < 4; i++) s[i] = px(48 + i, 1);
         for (int i = 0; i < 4; i++) d[i] = px(8 + i, 30 + t);
         run(32'h01200301 | (t << 22), pk(48, 1), pk(8, 30 + t), pk(4, 1));
         for (int i = 0; i < 4; i++)
            chk("expand pixel", px(8 + i, 30 + t), s[i][1] ? 8'hC3 : (t ? d[i] : 8'h3C));
      end
   endtask
   // Tile wraps after 32 pixels; window tag denial blocks writes.
   task automatic t_tile;
      logic [7:0] d [2];
      run(32'h00100301, pk(64, 0), pk(0, 40), pk(34, 1));
      for (int i = 0; i < 34; i++) chk("tile pixel", px(i, 40), px(64 + i % 32, 0));
      d[0] = px(5, 50);
      d[1] = px(6, 50);
      wid_ok <= 1'b0;
      run(32'h00080F01, pk(48, 0), pk(5, 50), pk(2, 1));
      wid_ok <= 1'b1;
      for (int i = 0; i < 2; i++) chk("tag clip", px(5 + i, 50), d[i]);
   endtask
   // Readout read at once, in order, one pixel word each.
   task automatic t_readout;
      logic [31:0] q;
      logic [1:0] r;
      int n;
      idle();
      slow <= 1'b1;
      n = irqs;
      wr(`OFS_COMMAND, {28'h0, `CODE_READOUT});
      wr(`OFS_EXTENT, pk(3, 2));
      wr(`OFS_WINDOW, pk(1, 2));
      wr(`OFS_CORNER, pk(3, 4));
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, `OFS_DATAPORT, 32'h0, q, r);
         chk("readout word", {r, q[29:0]}, {`RESP_OKAY, 22'h0, px(4 + i % 3, 6 + i / 3)});
      end
      idle();
      chk("readout done", irqs - n, 1);
   endtask
   // Main sequence.
   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      t_regs();
      t_logic();
      t_solid();
      t_expand();
      t_tile();
      t_readout();
      results();
   end
endmodule
bind block_copy_and_readout_engine engine_props u_props (.*);
`default_nettype wire
